// file: verilog/stepper_map.vh
// Constants of the stepper drive control logic: codes, offsets, timing
`ifndef STEPPER_MAP_VH
`define STEPPER_MAP_VH

`define CLK_MHZ 50
`define CLK_KHZ 50000

// Mode codes as {mode_select_bit1, mode_select_bit0}, switch on reads 1
`define MODE_ANALOG 2'h3
`define MODE_TWO_SPEED 2'h2
`define MODE_EXT_KNOB 2'h1
`define MODE_STEP_DIR 2'h0

// Microstep code {bit1, bit0}; 3 default, 2 = 400, 1 = 1600, 0 = 12800
`define MSTEP_DEFAULT 2'h3

// Times in their own units
`define TUNE_WINDOW_MS 1000
`define RAMP_TICK_US 1000
`define IDLE_DELAY_MS 500
`define FILTER_NS 160

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_IDLE_DELAY 8'h04
`define REG_STATUS 8'h08
`define REG_SPEED 8'h0c
`define REG_STEP_COUNT 8'h10

// Control register fields and reset value
`define CTRL_SOFT_STOP 0
`define CTRL_FORCE_OFF 1
`define CTRL_RESET 2'h0

// Status register fields
`define ST_MODE_LSB 0
`define ST_RUN 2
`define ST_DIR 3
`define ST_POS_LIMIT 4
`define ST_NEG_LIMIT 5
`define ST_POWER_ON 6
`define ST_IDLE_LOW 7
`define ST_TUNE_ARMED 8
`define ST_CURRENT_LSB 16
`define ST_MSTEP_LSB 20

// Speed register fields
`define SPD_TARGET_LSB 16

// Width of the ramp increment taken from the top of a knob reading
`define RATE_BITS 6

// AHB transfer type bit that marks NONSEQ or SEQ
`define HTRANS_ACTIVE 1

`endif

// file: verilog/input_filter.v
// Two-stage synchroniser and glitch filter for a group of digital inputs
`timescale 1ns/100ps
module input_filter #(
    parameter WIDTH = 5,
    parameter FILTER_CYCLES = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire [WIDTH-1:0] raw_in,
    output wire [WIDTH-1:0] clean_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg [15:0] cnt_q;
            reg bit_q;
            // A level must stay different for the whole count to pass
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q <= 16'h0000;
                    bit_q <= 1'b0;
                end else if (sync_q[i] == bit_q) begin
                    cnt_q <= 16'h0000;
                end else if (cnt_q >= FILTER_CYCLES - 1) begin
                    cnt_q <= 16'h0000;
                    bit_q <= sync_q[i];
                end else begin
                    cnt_q <= cnt_q + 16'h0001;
                end
            end
            assign clean_out[i] = bit_q;
        end
    endgenerate
endmodule // input_filter

// file: verilog/stepper_drive_logic.v
// Stepper drive control: mode latch, input routing, ramps, AHB registers
//
// Notes on behaviour
// - Two mode switches pick analog, two-speed, external knob or step/dir.
// - Mode switches are read once after reset; later changes are ignored.
// - Terminal two is run/stop in velocity modes, step pulse in step/dir.
// - Terminal three is direction, except positive limit in external knob.
// - An active limit ramps speed to zero at the ramp knob rate.
// - External knob mode honours positive limit only with analog upper half.
// - Terminal four is speed select, negative limit, or unused per mode.
// - External knob mode honours negative limit only with analog lower half.
// - Analog mode honours negative limit only while direction sits at ground.
// - Power stage is on while enable input is open, off when driven.
// - Microstep switches pick default, 400, 1600 or 12800; step/dir only.
// - Three current switches give eight running current levels.
// - Idle switch on lowers current when no steps arrive; off keeps it.
// - Two idle switch toggles within one second start auto tuning.
// - Knobs set accel, decel/low speed, high speed per mode.
// - Analog mode speed tracks the analog input continuously.
// - Two-speed mode picks low or high preset by speed select input.
`timescale 1ns/100ps
`include "stepper_map.vh"
module stepper_drive_logic #(
    parameter ANALOG_W = 10,
    parameter ACC_W = 24,
    parameter FILTER_CYCLES = (`FILTER_NS * `CLK_MHZ + 999) / 1000,
    parameter TUNE_WINDOW_CYCLES = `TUNE_WINDOW_MS * `CLK_KHZ,
    parameter RAMP_TICK_CYCLES = `RAMP_TICK_US * `CLK_MHZ,
    parameter [31:0] IDLE_DELAY_RESET = `IDLE_DELAY_MS * `CLK_KHZ
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire mode_select_bit0,
    input wire mode_select_bit1,
    input wire microstep_select_bit0,
    input wire microstep_select_bit1,
    input wire current_select_bit0,
    input wire current_select_bit1,
    input wire current_select_bit2,
    input wire idle_reduce_switch,
    input wire run_step_in,
    input wire dir_pos_limit_in,
    input wire speed_neg_limit_in,
    input wire disable_in,
    input wire [ANALOG_W-1:0] analog_level,
    input wire [ANALOG_W-1:0] accel_or_ramp_knob,
    input wire [ANALOG_W-1:0] decel_or_slow_knob,
    input wire [ANALOG_W-1:0] fast_speed_knob,
    output reg step_out,
    output reg dir_out,
    output reg run_active,
    output reg power_stage_en,
    output reg [1:0] microstep_code,
    output reg [2:0] current_level,
    output reg idle_reduce_active,
    output reg autotune_start,
    output reg [ANALOG_W-1:0] speed_command
);
    localparam TUNE_WAIT = 3'b001;
    localparam TUNE_ONE = 3'b010;
    localparam TUNE_GO = 3'b100;
    localparam [ANALOG_W-1:0] SPEED_ZERO = {ANALOG_W{1'b0}};

    // Input conditioning
    wire [4:0] clean;
    input_filter #(
        .WIDTH(5),
        .FILTER_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw_in({idle_reduce_switch, disable_in, speed_neg_limit_in,
            dir_pos_limit_in, run_step_in}),
        .clean_out(clean)
    );
    wire in2 = clean[0];
    wire in3 = clean[1];
    wire in4 = clean[2];
    wire dis_in = clean[3];
    wire idle_sw = clean[4];

    // Mode latched once after reset release
    reg mode_taken_q;
    reg [1:0] mode_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_taken_q <= 1'b0;
            mode_q <= `MODE_STEP_DIR;
        end else if (!mode_taken_q) begin
            mode_taken_q <= 1'b1;
            mode_q <= {mode_select_bit1, mode_select_bit0};
        end
    end
    wire is_analog = mode_taken_q && (mode_q == `MODE_ANALOG);
    wire is_two = mode_taken_q && (mode_q == `MODE_TWO_SPEED);
    wire is_ext = mode_taken_q && (mode_q == `MODE_EXT_KNOB);
    wire is_stepdir = mode_taken_q && (mode_q == `MODE_STEP_DIR);

    // Registers
    reg [1:0] ctrl_q;
    reg [31:0] idle_delay_q;
    reg [31:0] step_count_q;
    reg [ANALOG_W-1:0] cur_q;
    reg [ANALOG_W-1:0] target;
    reg [2:0] tune_q;

    // Limits and routing
    wire upper = analog_level[ANALOG_W-1];
    wire pos_limit = is_ext && in3 && upper;
    wire neg_limit = in4 && ((is_ext && !upper)
        || (is_analog && !in3));
    wire limit_hit = pos_limit || neg_limit;
    wire run_cmd = (is_analog || is_two || is_ext) && in2
        && !ctrl_q[`CTRL_SOFT_STOP];
    wire dir_req = is_ext ? upper : in3;

    // Distance from mid-scale, doubled, as speed in external knob mode
    wire [ANALOG_W-1:0] ext_mag = upper ?
        {analog_level[ANALOG_W-2:0], 1'b0} :
        {~analog_level[ANALOG_W-2:0], 1'b1};
    wire [2*ANALOG_W-1:0] analog_prod = analog_level * fast_speed_knob;
    wire [2*ANALOG_W-1:0] ext_prod = ext_mag * fast_speed_knob;

    always @* begin
        target = SPEED_ZERO;
        if (run_cmd && !limit_hit && dir_req == dir_out) begin
            if (is_analog)
                target = analog_prod[2*ANALOG_W-1:ANALOG_W];
            else if (is_ext)
                target = ext_prod[2*ANALOG_W-1:ANALOG_W];
            else if (is_two)
                target = in4 ? fast_speed_knob : decel_or_slow_knob;
        end
    end

    // Ramp rate: two-speed and limit stops use the ramp knob both ways
    wire use_ramp = is_two || limit_hit;
    wire [ANALOG_W-1:0] rate_up = {{(ANALOG_W-`RATE_BITS){1'b0}},
        accel_or_ramp_knob[ANALOG_W-1 -: `RATE_BITS]} + 1'b1;
    wire [ANALOG_W-1:0] rate_dn = {{(ANALOG_W-`RATE_BITS){1'b0}},
        (use_ramp ? accel_or_ramp_knob[ANALOG_W-1 -: `RATE_BITS] :
        decel_or_slow_knob[ANALOG_W-1 -: `RATE_BITS])} + 1'b1;

    reg [31:0] ramp_cnt_q;
    wire ramp_tick = (ramp_cnt_q >= RAMP_TICK_CYCLES - 1);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ramp_cnt_q <= 32'h0;
        else if (ramp_tick)
            ramp_cnt_q <= 32'h0;
        else
            ramp_cnt_q <= ramp_cnt_q + 32'h1;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_q <= SPEED_ZERO;
        end else if (ramp_tick) begin
            if (cur_q < target) begin
                if (target - cur_q > rate_up)
                    cur_q <= cur_q + rate_up;
                else
                    cur_q <= target;
            end else if (cur_q > target) begin
                if (cur_q - target > rate_dn)
                    cur_q <= cur_q - rate_dn;
                else
                    cur_q <= target;
            end
        end
    end

    // Phase accumulator: its carry is the generated step
    reg [ACC_W:0] acc_q;
    reg in2_prev_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= {(ACC_W+1){1'b0}};
            in2_prev_q <= 1'b0;
        end else begin
            acc_q <= {1'b0, acc_q[ACC_W-1:0]}
                + {{(ACC_W+1-ANALOG_W){1'b0}}, cur_q};
            in2_prev_q <= in2;
        end
    end
    wire ext_step = is_stepdir && in2 && !in2_prev_q;
    wire gen_step = !is_stepdir && acc_q[ACC_W] && (cur_q != SPEED_ZERO);
    wire any_step = ext_step || gen_step;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_out <= 1'b0;
            dir_out <= 1'b0;
            run_active <= 1'b0;
            speed_command <= SPEED_ZERO;
            step_count_q <= 32'h0;
        end else begin
            step_out <= any_step;
            // Outside step/dir, direction only flips at standstill so the motor never reverses
            // at speed; the target is held at zero until then
            if (is_stepdir || cur_q == SPEED_ZERO)
                dir_out <= dir_req;
            run_active <= run_cmd && !limit_hit;
            speed_command <= cur_q;
            if (any_step)
                step_count_q <= step_count_q + 32'h1;
        end
    end

    // Switch-driven settings, power stage and idle current
    reg [31:0] idle_cnt_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_stage_en <= 1'b0;
            microstep_code <= `MSTEP_DEFAULT;
            current_level <= 3'h0;
            idle_reduce_active <= 1'b0;
            idle_cnt_q <= 32'h0;
        end else begin
            power_stage_en <= !dis_in && !ctrl_q[`CTRL_FORCE_OFF];
            microstep_code <= is_stepdir ?
                {microstep_select_bit1, microstep_select_bit0} :
                `MSTEP_DEFAULT;
            current_level <= {current_select_bit2, current_select_bit1,
                current_select_bit0};
            if (any_step)
                idle_cnt_q <= 32'h0;
            else if (idle_cnt_q != 32'hffffffff)
                idle_cnt_q <= idle_cnt_q + 32'h1;
            idle_reduce_active <= idle_sw && !any_step
                && (idle_cnt_q >= idle_delay_q);
        end
    end

    // The filter leaves reset at 0, so a switch left on at power-up
    // looks like a toggle; arming waits FILTER_CYCLES + 4 cycles after reset for the filter to settle
    reg [15:0] settle_q;
    wire settled = (settle_q >= FILTER_CYCLES + 4);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            settle_q <= 16'h0000;
        else if (!settled)
            settle_q <= settle_q + 16'h0001;
    end

    // Auto tuning: two toggles of the idle switch inside the window
    reg idle_sw_prev_q;
    reg [31:0] win_cnt_q;
    wire sw_toggle = idle_sw != idle_sw_prev_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tune_q <= TUNE_WAIT;
            idle_sw_prev_q <= 1'b0;
            win_cnt_q <= 32'h0;
            autotune_start <= 1'b0;
        end else begin
            idle_sw_prev_q <= idle_sw;
            autotune_start <= 1'b0;
            case (tune_q)
                TUNE_WAIT: begin
                    win_cnt_q <= 32'h0;
                    if (sw_toggle && settled)
                        tune_q <= TUNE_ONE;
                end
                TUNE_ONE: begin
                    win_cnt_q <= win_cnt_q + 32'h1;
                    if (sw_toggle)
                        tune_q <= TUNE_GO;
                    else if (win_cnt_q >= TUNE_WINDOW_CYCLES - 1)
                        tune_q <= TUNE_WAIT;
                end
                TUNE_GO: begin
                    autotune_start <= 1'b1;
                    tune_q <= TUNE_WAIT;
                end
                default: tune_q <= TUNE_WAIT;
            endcase
        end
    end

    // AHB-Lite slave: zero wait states, read data set at the address phase
    wire addr_ok = hsel && htrans[`HTRANS_ACTIVE] && hready;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    reg [31:0] rd_mux;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @* begin
        rd_mux = 32'h0;
        case (haddr)
            `REG_CTRL: rd_mux[1:0] = ctrl_q;
            `REG_IDLE_DELAY: rd_mux = idle_delay_q;
            `REG_STATUS: begin
                rd_mux[`ST_MODE_LSB +: 2] = mode_q;
                rd_mux[`ST_RUN] = run_active;
                rd_mux[`ST_DIR] = dir_out;
                rd_mux[`ST_POS_LIMIT] = pos_limit;
                rd_mux[`ST_NEG_LIMIT] = neg_limit;
                rd_mux[`ST_POWER_ON] = power_stage_en;
                rd_mux[`ST_IDLE_LOW] = idle_reduce_active;
                rd_mux[`ST_TUNE_ARMED] = tune_q[1];
                rd_mux[`ST_CURRENT_LSB +: 3] = current_level;
                rd_mux[`ST_MSTEP_LSB +: 2] = microstep_code;
            end
            `REG_SPEED: begin
                rd_mux[ANALOG_W-1:0] = cur_q;
                rd_mux[`SPD_TARGET_LSB +: ANALOG_W] = target;
            end
            `REG_STEP_COUNT: rd_mux = step_count_q;
            default: rd_mux = 32'h0;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h0;
            ctrl_q <= `CTRL_RESET;
            idle_delay_q <= IDLE_DELAY_RESET;
        end else begin
            if (hready) begin
                wr_pend_q <= addr_ok && hwrite;
                wr_addr_q <= haddr;
            end
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `REG_CTRL: ctrl_q <= hwdata[1:0];
                    `REG_IDLE_DELAY: idle_delay_q <= hwdata;
                    default: ctrl_q <= ctrl_q;
                endcase
            end
        end
    end
endmodule // stepper_drive_logic

// file: testbench/controller_model.sv
// Behavioural motion controller, limit switches and analog speed source
`timescale 1ns/100ps
module controller_model (
    input wire hclk,
    output reg run_step_in,
    output reg dir_pos_limit_in,
    output reg speed_neg_limit_in,
    output reg disable_in,
    output reg [9:0] analog_level
);
    initial begin
        run_step_in = 1'b0;
        dir_pos_limit_in = 1'b0;
        speed_neg_limit_in = 1'b0;
        disable_in = 1'b0;
        analog_level = 10'h000;
    end
    task set_lines(input r, input d, input s, input x, input [9:0] a);
        @(posedge hclk);
        run_step_in <= r;
        dir_pos_limit_in <= d;
        speed_neg_limit_in <= s;
        disable_in <= x;
        analog_level <= a;
    endtask
    // A width below the filter length is a deliberate glitch
    task steps(input integer n, input integer w);
        integer i;
        for (i = 0; i < n; i++) begin
            @(posedge hclk);
            run_step_in <= 1'b1;
            repeat (w) @(posedge hclk);
            run_step_in <= 1'b0;
            repeat (w) @(posedge hclk);
        end
    endtask
endmodule // controller_model

// file: testbench/stepper_drive_props.sv
// Concurrent checks on the stepper drive control ports
`timescale 1ns/100ps
`include "stepper_map.vh"
module stepper_drive_props #(
    parameter ANALOG_W = 10
) (
    input wire hclk,
    input wire hresetn,
    input wire mode_select_bit0,
    input wire mode_select_bit1,
    input wire current_select_bit0,
    input wire current_select_bit1,
    input wire current_select_bit2,
    input wire idle_reduce_switch,
    input wire dir_pos_limit_in,
    input wire speed_neg_limit_in,
    input wire disable_in,
    input wire [ANALOG_W-1:0] analog_level,
    input wire step_out,
    input wire run_active,
    input wire power_stage_en,
    input wire [1:0] microstep_code,
    input wire [2:0] current_level,
    input wire idle_reduce_active,
    input wire autotune_start
);
    reg got_q;
    reg [1:0] mode_q;
    // Mirror of the mode latch, taken at the first edge after reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            got_q <= 1'b0;
            mode_q <= 2'h0;
        end else if (!got_q) begin
            got_q <= 1'b1;
            mode_q <= {mode_select_bit1, mode_select_bit0};
        end
    end
    wire up = analog_level[ANALOG_W-1];
    wire ext_m = got_q && mode_q == `MODE_EXT_KNOB;
    wire ana_m = got_q && mode_q == `MODE_ANALOG;
    wire [2:0] cur = {current_select_bit2, current_select_bit1,
        current_select_bit0};
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Long enough to cover synchroniser, filter and output register
    sequence held(x);
        x [*8] ##1 x [*6];
    endsequence
    a_step_single: assert property (step_out |=> !step_out)
        else $error("step pulse longer than one cycle");
    a_tune_single: assert property (autotune_start |=> !autotune_start)
        else $error("tune start longer than one cycle");
    a_power_disabled: assert property (held(disable_in) |-> !power_stage_en)
        else $error("power stage on while disabled");
    a_mstep_default: assert property (got_q && mode_q != `MODE_STEP_DIR
        |-> microstep_code == `MSTEP_DEFAULT)
        else $error("microstep not default in velocity mode");
    a_current_follow: assert property (held($stable(cur))
        |-> current_level == cur)
        else $error("current level does not follow switches");
    a_pos_limit_ext: assert property (held(ext_m && dir_pos_limit_in && up)
        |-> !run_active)
        else $error("positive limit ignored in upper half");
    a_neg_limit_ext: assert property (held(ext_m && speed_neg_limit_in && !up)
        |-> !run_active)
        else $error("negative limit ignored in lower half");
    a_neg_limit_ana: assert property (held(ana_m && speed_neg_limit_in &&
        !dir_pos_limit_in) |-> !run_active)
        else $error("negative limit ignored in analog mode");
    a_idle_kept: assert property (held(!idle_reduce_switch)
        |-> !idle_reduce_active)
        else $error("current reduced with idle switch off");
endmodule // stepper_drive_props
bind stepper_drive_logic stepper_drive_props #(.ANALOG_W(ANALOG_W))
    u_stepper_drive_props (.hclk, .hresetn, .mode_select_bit0,
    .mode_select_bit1, .current_select_bit0, .current_select_bit1,
    .current_select_bit2, .idle_reduce_switch, .dir_pos_limit_in,
    .speed_neg_limit_in, .disable_in, .analog_level, .step_out, .run_active,
    .power_stage_en, .microstep_code, .current_level, .idle_reduce_active,
    .autotune_start);

// file: testbench/stepper_drive_logic_tb_top.sv
// Self-checking bench for the stepper drive control logic
`timescale 1ns/100ps
`include "stepper_map.vh"
module stepper_drive_logic_tb_top;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0;
    reg mode_select_bit0 = 1'b0, mode_select_bit1 = 1'b0;
    reg microstep_select_bit0 = 1'b1, microstep_select_bit1 = 1'b1;
    reg current_select_bit0 = 1'b0, current_select_bit1 = 1'b0;
    reg current_select_bit2 = 1'b0, idle_reduce_switch = 1'b0;
    reg [9:0] accel_or_ramp_knob = 10'h3ff, decel_or_slow_knob = 10'h3ff;
    reg [9:0] fast_speed_knob = 10'h000;
    wire hreadyout, hresp, step_out, dir_out, run_active, power_stage_en;
    wire idle_reduce_active, autotune_start, run_step_in, dir_pos_limit_in;
    wire speed_neg_limit_in, disable_in;
    wire [31:0] hrdata;
    wire [1:0] microstep_code;
    wire [2:0] current_level;
    wire [9:0] speed_command, analog_level;
    integer n_errors = 0, checks = 0, n_steps = 0, n_tune = 0, i, j, b;
    reg [31:0] rd;
    reg [8:0] rows [0:7];
    reg [12:0] ext_rows [0:3];
    controller_model u_controller_model (.hclk, .run_step_in,
        .dir_pos_limit_in, .speed_neg_limit_in, .disable_in, .analog_level);
    stepper_drive_logic #(.TUNE_WINDOW_CYCLES(200), .RAMP_TICK_CYCLES(4))
        u_stepper_drive_logic (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .mode_select_bit0, .mode_select_bit1,
        .microstep_select_bit0, .microstep_select_bit1,
        .current_select_bit0, .current_select_bit1, .current_select_bit2,
        .idle_reduce_switch, .run_step_in, .dir_pos_limit_in,
        .speed_neg_limit_in, .disable_in, .analog_level,
        .accel_or_ramp_knob, .decel_or_slow_knob, .fast_speed_knob,
        .step_out, .dir_out, .run_active, .power_stage_en, .microstep_code,
        .current_level, .idle_reduce_active, .autotune_start,
        .speed_command);
    initial begin
        forever #10 hclk = ~hclk;
    end
    // Counted off the edge so a one-cycle pulse is seen exactly once
    always @(negedge hclk) begin
        if (step_out === 1'b1) n_steps <= n_steps + 1;
        if (autotune_start === 1'b1) n_tune <= n_tune + 1;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string w, input [31:0] s, input [31:0] e);
        checks = checks + 1;
        if (s !== e) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask
    task bus(input [7:0] a, input w, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task rst(input [1:0] m);
        @(posedge hclk);
        hresetn <= 1'b0;
        {mode_select_bit1, mode_select_bit0} <= m;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (20) @(posedge hclk);
    endtask
    initial begin
        #400000;
        n_errors = n_errors + 1;
        $display("watchdog expired");
        end_of_test;
    end
    initial begin
        // Rows: mode, microstep switches, current switches, microstep code
        rows[0] = 9'h063; rows[1] = 9'h0c7; rows[2] = 9'h12b;
        rows[3] = 9'h18f; rows[4] = 9'h052; rows[5] = 9'h035;
        rows[6] = 9'h018; rows[7] = 9'h0ff;
        // Rows: analog level, positive limit, negative limit, run expected
        ext_rows[0] = 13'h12c4; ext_rows[1] = 13'h0c85;
        ext_rows[2] = 13'h0c82; ext_rows[3] = 13'h12c3;
        for (i = 0; i < 8; i++) begin
            {microstep_select_bit1, microstep_select_bit0} <= rows[i][6:5];
            {current_select_bit2, current_select_bit1,
                current_select_bit0} <= rows[i][4:2];
            rst(rows[i][8:7]);
            chk("mstep", microstep_code, rows[i][1:0]);
            chk("current", current_level, rows[i][4:2]);
            bus(`REG_STATUS, 1'b0, 32'h0);
            chk("mode", rd[1:0], rows[i][8:7]);
        end
        $display("test table done");
        rst(`MODE_STEP_DIR);
        bus(`REG_CTRL, 1'b0, 32'h0);
        chk("ctrl reset", rd, `CTRL_RESET);
        bus(`REG_IDLE_DELAY, 1'b0, 32'h0);
        chk("idle delay reset", rd, 32'h017d7840);
        bus(8'h20, 1'b0, 32'h0);
        chk("unmapped", rd, 32'h0);
        {mode_select_bit1, mode_select_bit0} <= `MODE_ANALOG;
        bus(`REG_STATUS, 1'b0, 32'h0);
        chk("mode kept", rd[1:0], `MODE_STEP_DIR);
        b = n_steps;
        u_controller_model.steps(5, 10);
        u_controller_model.steps(1, 3);
        repeat (20) @(posedge hclk);
        chk("steps", n_steps - b, 5);
        u_controller_model.set_lines(1'b0, 1'b1, 1'b0, 1'b1, 10'h000);
        repeat (20) @(posedge hclk);
        chk("dir", dir_out, 1'b1);
        chk("disabled", power_stage_en, 1'b0);
        u_controller_model.set_lines(1'b0, 1'b1, 1'b0, 1'b0, 10'h000);
        repeat (20) @(posedge hclk);
        chk("enabled", power_stage_en, 1'b1);
        bus(`REG_CTRL, 1'b1, 32'h2);
        bus(`REG_CTRL, 1'b0, 32'h0);
        chk("ctrl rw", rd, 32'h2);
        chk("okay", hresp, 1'b0);
        chk("forced off", power_stage_en, 1'b0);
        bus(`REG_CTRL, 1'b1, 32'h0);
        $display("test step dir done");
        bus(`REG_IDLE_DELAY, 1'b1, 32'h32);
        b = n_tune;
        idle_reduce_switch <= 1'b1;
        repeat (300) @(posedge hclk);
        chk("idle low", idle_reduce_active, 1'b1);
        chk("no tune", n_tune - b, 0);
        idle_reduce_switch <= 1'b0;
        repeat (20) @(posedge hclk);
        chk("idle kept", idle_reduce_active, 1'b0);
        idle_reduce_switch <= 1'b1;
        repeat (20) @(posedge hclk);
        chk("tune", n_tune - b, 1);
        repeat (300) @(posedge hclk);
        idle_reduce_switch <= 1'b0;
        repeat (300) @(posedge hclk);
        idle_reduce_switch <= 1'b1;
        repeat (30) @(posedge hclk);
        chk("slow toggles", n_tune - b, 1);
        $display("test idle done");
        rst(`MODE_EXT_KNOB);
        fast_speed_knob <= 10'h1f4;
        for (i = 0; i < 4; i++) begin
            u_controller_model.set_lines(1'b1, ext_rows[i][2],
                ext_rows[i][1], 1'b0, ext_rows[i][12:3]);
            repeat (40) @(posedge hclk);
            chk("ext run", run_active, ext_rows[i][0]);
        end
        $display("test external knob done");
        rst(`MODE_ANALOG);
        fast_speed_knob <= 10'h190;
        u_controller_model.set_lines(1'b1, 1'b0, 1'b0, 1'b0, 10'h200);
        repeat (60) @(posedge hclk);
        bus(`REG_SPEED, 1'b0, 32'h0);
        chk("target", rd[25:16], 10'h0c8);
        chk("speed", speed_command, 10'h0c8);
        u_controller_model.set_lines(1'b1, 1'b0, 1'b1, 1'b0, 10'h200);
        for (j = 0; j < 40 && run_active !== 1'b0; j++) @(posedge hclk);
        chk("stopped", run_active, 1'b0);
        chk("ramping", speed_command != 10'h000, 1'b1);
        repeat (60) @(posedge hclk);
        chk("at rest", speed_command, 10'h000);
        u_controller_model.set_lines(1'b1, 1'b1, 1'b1, 1'b0, 10'h200);
        repeat (60) @(posedge hclk);
        chk("other dir", run_active, 1'b1);
        $display("test analog done");
        rst(`MODE_TWO_SPEED);
        decel_or_slow_knob <= 10'h064;
        fast_speed_knob <= 10'h12c;
        for (i = 0; i < 2; i++) begin
            u_controller_model.set_lines(1'b1, 1'b0, i[0], 1'b0, 10'h000);
            repeat (40) @(posedge hclk);
            bus(`REG_SPEED, 1'b0, 32'h0);
            chk("two speed", rd[25:16], i ? 10'h12c : 10'h064);
        end
        $display("test two speed done");
        end_of_test;
    end
endmodule // stepper_drive_logic_tb_top
